/* verilog/ana_pkg.sv */
/*
  ana_pkg: constants for the auto-negotiation advertisement register block.
  assumes a 32-bit apb slave with the register word at byte offset 0x04 and a restart strobe at 0x08.
*/
package ana_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADV_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] RESTART_OFFSET = 8'h08;
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [4:0] SELECTOR_VALUE = 5'h01;
  localparam int unsigned NEXT_PAGE_BIT = 15;
  localparam int unsigned REMOTE_FAULT_BIT = 13;
  localparam logic [15:0] SELECTOR_MASK = 16'h001f;
  localparam int unsigned ABIL_HI = 8;
  localparam int unsigned ABIL_LO = 5;
  localparam int unsigned RESTART_BIT = 9;
  localparam logic [15:0] WRITE_MASK = 16'h21e0;
  localparam logic [15:0] HALF_MASK = 16'hffff;
  localparam logic [3:0] ABIL_RESET = 4'hf;
  typedef enum logic [1:0] {
    ANA_IDLE,
    ANA_ACCESS,
    ANA_DONE
  } ana_state_t;
endpackage

/* verilog/ana_latch.sv */
/*
  ana_latch: copies the stored advertisement onto the link-side word on restart.
  assumes load_i is a one-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
module ana_latch (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic load_i,
  input wire logic [15:0] stored_i,
  output logic [15:0] link_word_o
);
  import ana_pkg::*;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_word_o <= ADV_RESET;
    end else if (load_i) begin
      link_word_o <= stored_i;
    end
  end

  AST_LINK_HOLDS: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(load_i) |-> $stable(link_word_o)) else $error("link word moved without restart");
endmodule // ana_latch

/* verilog/ana_adv_reg.sv */
/*
  ana_adv_reg: apb slave holding the auto-negotiation advertisement register.
  assumes an apb master on clk_i; the negotiation engine pulses restart externally.
*/
`timescale 1ns/1ps
// Overview of operation
// - 16-bit read/write register, reset value 0x01e1
// - writes reach link only after restart
// - bits 8:5 writable abilities, reset to one
// - bit 15 next page reads zero
// - bit 13 writable remote fault, resets zero
// - bits 14, 12:9 read zero
// - selector bits 4:0 fixed at 0x01
module ana_adv_reg (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ana_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic restart_negotiation_i,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] advertised_word_o,
  output logic adv_100tx_full_o,
  output logic adv_100tx_half_o,
  output logic adv_10t_full_o,
  output logic adv_10t_half_o,
  output logic remote_fault_advertise_o
);
  import ana_pkg::*;

  logic [3:0] ability_field;
  logic remote_fault_advertise;
  logic [15:0] stored_word;
  logic restart_pulse;
  logic sw_restart;
  logic access;
  logic hit_adv;
  logic hit_restart;
  logic [15:0] link_word;
  logic wr_adv;
  logic rd_setup;

  assign access = psel && penable;
  assign hit_adv = (paddr == ADV_OFFSET);
  assign hit_restart = (paddr == RESTART_OFFSET);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // shorthands used by the checks below
  assign wr_adv = access && pwrite && hit_adv;
  assign rd_setup = psel && !penable && !pwrite;

  // reserved and next page bits stay zero; selector is hard wired
  assign stored_word = {1'b0, 1'b0, remote_fault_advertise, 4'h0, ability_field,
    SELECTOR_VALUE};

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ability_field <= ABIL_RESET;
    end else if (access && pwrite && hit_adv) begin
      ability_field <= pwdata[ABIL_HI:ABIL_LO];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      remote_fault_advertise <= 1'b0;
    end else if (access && pwrite && hit_adv) begin
      remote_fault_advertise <= pwdata[REMOTE_FAULT_BIT];
    end
  end

  // software restart strobe stands in for the control register's restart bit
  assign sw_restart = access && pwrite && hit_restart && pwdata[RESTART_BIT];
  assign restart_pulse = sw_restart || restart_negotiation_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit_adv ? {16'h0, stored_word} : 32'h0;
    end
  end

  ana_latch u_latch (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(restart_pulse),
    .stored_i(stored_word),
    .link_word_o(link_word)
  );

  assign advertised_word_o = link_word;
  assign adv_100tx_full_o = link_word[ABIL_HI];
  assign adv_100tx_half_o = link_word[ABIL_HI-1];
  assign adv_10t_full_o = link_word[ABIL_LO+1];
  assign adv_10t_half_o = link_word[ABIL_LO];
  assign remote_fault_advertise_o = link_word[REMOTE_FAULT_BIT];

  AST_RESET_VALUE: assert property (@(posedge clk_i)
    $fell(reset_i) |-> stored_word == ADV_RESET) else $error("bad reset value");
  AST_NP_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    stored_word[NEXT_PAGE_BIT] == 1'b0) else $error("next page bit set");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    (stored_word & ~WRITE_MASK & ~SELECTOR_MASK) == 16'h0) else $error("reserved bit set");
  AST_SELECTOR: assert property (@(posedge clk_i) disable iff (reset_i)
    stored_word[4:0] == SELECTOR_VALUE) else $error("selector changed");
  AST_ABIL_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    access && pwrite && hit_adv |=> ability_field == $past(pwdata[ABIL_HI:ABIL_LO]))
    else $error("ability write lost");
  AST_RF_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    access && pwrite && hit_adv |=> remote_fault_advertise == $past(pwdata[REMOTE_FAULT_BIT]))
    else $error("remote fault write lost");
  AST_LINK_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
    restart_pulse |=> advertised_word_o == $past(stored_word)) else $error("restart not applied");
  AST_MAP: assert property (@(posedge clk_i) disable iff (reset_i)
    {adv_100tx_full_o, adv_100tx_half_o, adv_10t_full_o, adv_10t_half_o} ==
    advertised_word_o[ABIL_HI:ABIL_LO]) else $error("ability map wrong");
  AST_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    psel && !penable && !pwrite && hit_adv |=> prdata[15:0] == $past(stored_word))
    else $error("read data wrong");

  COV_WRITE: cover property (@(posedge clk_i) access && pwrite && hit_adv);
  COV_RESTART: cover property (@(posedge clk_i) sw_restart);
  COV_CLEAR_THEN_RESTART: cover property (@(posedge clk_i)
    (access && pwrite && hit_adv && pwdata[ABIL_HI] == 1'b0) ##[1:20] restart_pulse);
  COV_READ: cover property (@(posedge clk_i) rd_setup && hit_adv);
  COV_REMOTE_FAULT: cover property (@(posedge clk_i) remote_fault_advertise_o);

  // bus side: zero wait states, never an error response

  AST_PREADY_HIGH: assert property (@(posedge clk_i) disable iff (reset_i)
    pready == 1'b1)
    else $error("wait state inserted");

  AST_NO_SLVERR: assert property (@(posedge clk_i) disable iff (reset_i)
    pslverr == 1'b0)
    else $error("error response raised");

  AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    prdata[31:16] == 16'h0)
    else $error("upper read half not zero");

  // unmapped addresses read zero so software never sees stale data
  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_setup && !hit_adv |=> prdata == 32'h0)
    else $error("unmapped read not zero");

  AST_PRDATA_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_setup |=> $stable(prdata))
    else $error("read data moved outside setup");

  AST_RESET_PRDATA: assert property (@(posedge clk_i)
    $fell(reset_i) |-> prdata == 32'h0)
    else $error("read data not cleared by reset");

  // stored fields only move on a write to this register

  AST_ABIL_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    !wr_adv |=> $stable(ability_field))
    else $error("ability field moved without write");

  AST_RF_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    !wr_adv |=> $stable(remote_fault_advertise))
    else $error("remote fault moved without write");

  AST_RESET_ABIL: assert property (@(posedge clk_i)
    $fell(reset_i) |-> ability_field == ABIL_RESET)
    else $error("ability field not reset to ones");

  AST_RESET_RF: assert property (@(posedge clk_i)
    $fell(reset_i) |-> remote_fault_advertise == 1'b0)
    else $error("remote fault not reset to zero");

  // link side: the advertised word only changes on a restart

  AST_LINK_STEADY: assert property (@(posedge clk_i) disable iff (reset_i)
    !restart_pulse |=> $stable(advertised_word_o))
    else $error("advertised word moved without restart");

  AST_RESET_LINK: assert property (@(posedge clk_i)
    $fell(reset_i) |-> advertised_word_o == ADV_RESET)
    else $error("advertised word not reset");

  // a restart write with the trigger bit clear must not restart
  AST_RESTART_BIT: assert property (@(posedge clk_i) disable iff (reset_i)
    access && pwrite && hit_restart && !pwdata[RESTART_BIT] && !restart_negotiation_i
    |=> $stable(advertised_word_o))
    else $error("restart without trigger bit");

  AST_LINK_NP_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    advertised_word_o[NEXT_PAGE_BIT] == 1'b0)
    else $error("next page advertised");

  AST_LINK_RSVD: assert property (@(posedge clk_i) disable iff (reset_i)
    (advertised_word_o & ~WRITE_MASK & ~SELECTOR_MASK) == 16'h0)
    else $error("reserved bit advertised");

  AST_LINK_SELECTOR: assert property (@(posedge clk_i) disable iff (reset_i)
    advertised_word_o[4:0] == SELECTOR_VALUE)
    else $error("advertised selector wrong");

  AST_RF_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
    remote_fault_advertise_o == advertised_word_o[REMOTE_FAULT_BIT])
    else $error("remote fault output wrong");

  // limitation: both restart strobes in one cycle act as a single restart
endmodule // ana_adv_reg

/* sim/ana_link_partner.sv */
/*
  ana_link_partner: behavioural far-end phy that sees the advertised word.
  assumes the advertised word is stable between restarts, same clock.
*/
`timescale 1ns/1ps
module ana_link_partner #(
  parameter logic [3:0] OWN_ABIL = 4'hf
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] advertised_word_i,
  output logic [3:0] common_o
);
  // modes both ends support; a cleared local bit drops the mode
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      common_o <= 4'h0;
    end else begin
      common_o <= advertised_word_i[8:5] & OWN_ABIL;
    end
  end
endmodule // ana_link_partner

/* sim/ana_adv_reg_tb.sv */
/*
  ana_adv_reg_tb: apb read/write tests of the advertisement register.
  assumes zero-wait apb slave and a one-cycle restart path.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module ana_adv_reg_tb;
  import ana_pkg::*;
  logic clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, rpulse = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, f100, h100, f10, h10, rf;
  logic [15:0] adv;
  logic [3:0] common;
  int err_count = 0, total_checks = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  ana_adv_reg uut (.clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .restart_negotiation_i(rpulse),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .advertised_word_o(adv),
    .adv_100tx_full_o(f100), .adv_100tx_half_o(h100), .adv_10t_full_o(f10),
    .adv_10t_half_o(h10), .remote_fault_advertise_o(rf));
  ana_link_partner #(.OWN_ABIL(4'h6)) lp (.clk_i(clk_i), .reset_i(reset_i),
    .advertised_word_i(adv), .common_o(common));
  task finish_test;
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task pulse;
    rpulse <= 1'b1;
    @(posedge clk_i);
    rpulse <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // hang guard, tests need about 62 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    for (int i = 0; i < 2; i++) begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      xfer(1'b0, ADV_OFFSET, 32'h0);
      `CHK(rv, 32'h000001e1)
      `CHK({adv, f100, h100, f10, h10, rf}, {16'h01e1, 5'h1e})
      xfer(1'b1, ADV_OFFSET, 32'hffffffff);
      xfer(1'b0, ADV_OFFSET, 32'h0);
      `CHK(rv, 32'h000021e1)
      `CHK(adv, 16'h01e1)
      xfer(1'b1, ADV_OFFSET, 32'h00000140);
      xfer(1'b1, RESTART_OFFSET, 32'h00000200);
      repeat (3) @(posedge clk_i);
      `CHK({adv, f100, h100, f10, h10, rf}, {16'h0141, 5'h14})
      `CHK(common, 4'h2)
      xfer(1'b1, ADV_OFFSET, 32'h00002000);
      pulse();
      `CHK({adv, rf}, {16'h2001, 1'b1})
      xfer(1'b0, 8'h0c, 32'h0);
      `CHK({rv, pslverr}, 33'h0)
      reset_i <= 1'b1;
    end
    finish_test;
  end
endmodule // ana_adv_reg_tb
